/* File: design/rtbf_pkg.sv */
/*
  Shared constants for the readout card, its distribution section and the
  personality logic. Assumes a 25 MHz clock on both ends.
*/
package rtbf_pkg;
  localparam int CLK_NS = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / CLK_NS / 2;
  localparam int STROBE_CYC = 4;
  localparam int SYSRST_CYC = 8;
  localparam int NUM_SLOTS = 21;
  localparam int NUM_CARDS = 16;
  localparam int NUM_PARTS = 8;
  localparam int DATA_W = 16;
  localparam int TS_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AFULL = 12;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FIRE = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_FIFO = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TX = 8'h14;
  localparam logic [7:0] REG_RX = 8'h18;
  // Field positions.
  localparam int CTRL_GEN = 0;
  localparam int CTRL_PART = 1;
  localparam int CTRL_DIR = 4;
  localparam int FIRE_TRIG = 0;
  localparam int FIRE_CAL = 1;
  localparam int FIRE_RST = 2;
  localparam int FIFO_VALID = 16;
  localparam int ST_FULL = 8;
  localparam int ST_THR = 9;
  localparam int ST_ERR = 10;
  localparam int ST_PERR = 11;
  localparam int ST_TXP = 12;
  localparam int ST_RXV = 13;
  localparam int RX_EVT = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage : rtbf_pkg

/* File: design/rtbf_pif.sv */
/*
  Personality link between readout card and personality logic.
  Resolves the shared data bus from the two output enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface rtbf_pif;
  import rtbf_pkg::*;
  logic sclk;
  logic dir;
  logic out_avail;
  logic sys_rst;
  logic perr;
  logic [DATA_W-1:0] rc_data;
  logic rc_oe;
  logic [DATA_W-1:0] pl_data;
  logic pl_oe;
  logic [DATA_W-1:0] data;
  // Wire level of the shared bus; undriven reads as zero.
  assign data = rc_oe ? rc_data : (pl_oe ? pl_data : '0);
  modport card (input sclk, perr, data, output dir, out_avail, sys_rst, rc_data, rc_oe);
  modport pers (input dir, out_avail, sys_rst, data, output sclk, perr, pl_data, pl_oe);
endinterface : rtbf_pif
`default_nettype wire

/* File: design/rtbf_sync3.sv */
/*
  Three-flop input synchroniser with settle filter for a vector.
  Assumes inputs from another clock domain or from pins.
*/
`timescale 1ns/1ps
`default_nettype none
module rtbf_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Chain of three flops; the first is read only by the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) q_o[i] <= s3_r[i];
      end
    end
  end
endmodule : rtbf_sync3
`default_nettype wire

/* File: design/rtbf_readout_card.sv */
/*
  Readout card with its crate fast-control distribution section.
  Assumes a classic Wishbone master; bus and central inputs are asynchronous.
*/
// Operation
// - Card takes trigger, clock, reset from bus; code has no bus clock, card takes trigger and reset from bus and runs on clk_i.
// - Triggers time-stamped and queued for processor.
// - Throttle asserted at or above almost-full.
// - Trigger while queue full raises error.
// - Words cross personality link on parallel bus.
// - Each serial clock edge moves one word; code moves a word on the rising edge only.
// - Serial clock runs only during transfers.
// - System reset clears streams and serial counters.
// - One shared strobe advances all streams together.
// - Personality flags transmission errors to card.
// - Link carries data in both directions.
// - Distribution re-drives central signals onto bus.
// - Distribution can generate bus signals by program.
// - Programmed trigger or calibration at set moment.
// - Programmable partition selection.
// - Card throttle and error lines forwarded centrally.
// - Processor takes each trigger as interrupt; code has no interrupt, processor reads the queue over the register bus.
// - Controller waits for token before sending; code has no token, words go on out_avail or tx_valid_i.
// - Crate has 21 slots, 16 readout cards.
`timescale 1ns/1ps
`default_nettype none
module rtbf_readout_card
  import rtbf_pkg::*;
#(
  parameter int DEPTH = rtbf_pkg::FIFO_DEPTH,
  parameter int AFULL = rtbf_pkg::FIFO_AFULL,
  parameter int CARDS = rtbf_pkg::NUM_CARDS,
  parameter int SLOTS = rtbf_pkg::NUM_SLOTS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [rtbf_pkg::NUM_PARTS-1:0] cen_trig_i,
  input wire logic [rtbf_pkg::NUM_PARTS-1:0] cen_cal_i,
  input wire logic cen_rst_i,
  output logic fcb_trig_o,
  output logic fcb_cal_o,
  output logic fcb_rst_o,
  input wire logic fcb_trig_i,
  input wire logic fcb_rst_i,
  input wire logic [CARDS-1:0] card_throttle_i,
  input wire logic [CARDS-1:0] card_err_i,
  output logic cen_throttle_o,
  output logic cen_err_o,
  output logic throttle_o,
  output logic error_o,
  rtbf_pif.card pif
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = 2 * NUM_PARTS + 3 + 2 * CARDS + 2 + DATA_W;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || AFULL < 1 || AFULL > DEPTH || CARDS > SLOTS - 5)
      $error("rtbf_readout_card: unsupported parameters");
  end

  logic [SW-1:0] sync_q;
  logic [NUM_PARTS-1:0] c_trig, c_cal;
  logic c_rst, b_trig, b_rst, s_clk, s_perr;
  logic [CARDS-1:0] s_thr, s_err;
  logic [DATA_W-1:0] s_data;
  // Every outside level except the register bus and rst_i passes the settle-filtered synchroniser.
  rtbf_sync3 #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({cen_trig_i, cen_cal_i, cen_rst_i, fcb_trig_i, fcb_rst_i, card_throttle_i,
          card_err_i, pif.sclk, pif.perr, pif.data}),
    .q_o(sync_q)
  );
  assign {c_trig, c_cal, c_rst, b_trig, b_rst, s_thr, s_err, s_clk, s_perr, s_data} = sync_q;

  logic b_trig_d_r, b_rst_d_r, s_clk_d_r;
  logic trig_rise, frst_rise, sclk_rise;
  // Edge history of the settled levels.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b_trig_d_r <= 1'b0;
      b_rst_d_r <= 1'b0;
      s_clk_d_r <= 1'b0;
    end else begin
      b_trig_d_r <= b_trig;
      b_rst_d_r <= b_rst;
      s_clk_d_r <= s_clk;
    end
  end
  assign trig_rise = b_trig & ~b_trig_d_r;
  assign frst_rise = b_rst & ~b_rst_d_r;
  assign sclk_rise = s_clk & ~s_clk_d_r;

  // Register bus decode; a request is taken in the cycle before ack.
  logic acc, wr, rd;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & (wb_sel_i == 4'hF);
  assign rd = acc & ~wb_we_i;

  logic [31:0] ctrl_r;
  logic [15:0] delay_r;
  logic [15:0] fire_cnt_r;
  logic [2:0] fire_what_r;
  logic fire_pend_r;
  logic gen_go;
  // Control registers and programmed-moment countdown.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      delay_r <= 16'h0000;
      fire_cnt_r <= 16'h0000;
      fire_what_r <= 3'h0;
      fire_pend_r <= 1'b0;
    end else begin
      if (wr && wb_adr_i == REG_CTRL) ctrl_r <= wb_dat_i;
      if (wr && wb_adr_i == REG_DELAY) delay_r <= wb_dat_i[15:0];
      if (wr && wb_adr_i == REG_FIRE) begin
        fire_cnt_r <= delay_r;
        fire_what_r <= wb_dat_i[2:0];
        fire_pend_r <= |wb_dat_i[2:0];
      end else if (fire_pend_r) begin
        if (fire_cnt_r == 16'h0000) fire_pend_r <= 1'b0;
        else fire_cnt_r <= fire_cnt_r - 16'h0001;
      end
    end
  end
  assign gen_go = fire_pend_r && fire_cnt_r == 16'h0000;

  logic [2:0] part;
  logic [$clog2(STROBE_CYC+1)-1:0] str_cnt_r;
  logic [2:0] gen_r;
  assign part = ctrl_r[CTRL_PART +: 3];
  // Generated strobes are stretched so the bus filter sees them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      str_cnt_r <= '0;
      gen_r <= 3'h0;
    end else if (gen_go) begin
      // The load cycle counts as the first of the strobe's cycles.
      str_cnt_r <= ($clog2(STROBE_CYC+1))'(STROBE_CYC - 1);
      gen_r <= fire_what_r;
    end else if (str_cnt_r != '0) begin
      str_cnt_r <= str_cnt_r - 1'b1;
    end else begin
      gen_r <= 3'h0;
    end
  end

  // Bus drive: central signals of the chosen partition or our own.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcb_trig_o <= 1'b0;
      fcb_cal_o <= 1'b0;
      fcb_rst_o <= 1'b0;
    end else if (ctrl_r[CTRL_GEN]) begin
      fcb_trig_o <= gen_r[FIRE_TRIG];
      fcb_cal_o <= gen_r[FIRE_CAL];
      fcb_rst_o <= gen_r[FIRE_RST];
    end else begin
      fcb_trig_o <= c_trig[part];
      fcb_cal_o <= c_cal[part];
      fcb_rst_o <= c_rst;
    end
  end

  // Crate throttle and error gathering toward the central system.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cen_throttle_o <= 1'b0;
      cen_err_o <= 1'b0;
    end else begin
      cen_throttle_o <= |s_thr;
      cen_err_o <= |s_err;
    end
  end

  logic [TS_W-1:0] ts_r;
  logic [TS_W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic full, empty, push, pop;
  assign full = cnt_r == (AW+1)'(DEPTH);
  assign empty = cnt_r == '0;
  assign push = trig_rise & ~full;
  assign pop = rd && wb_adr_i == REG_FIFO && !empty;
  // Free-running time stamp, cleared by fast reset.
  always_ff @(posedge clk_i) begin
    if (rst_i || frst_rise) ts_r <= '0;
    else ts_r <= ts_r + 1'b1;
  end
  // Trigger queue; the processor drains it through the register bus.
  always_ff @(posedge clk_i) begin
    if (rst_i || frst_rise) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= ts_r;
        wp_r <= wp_r + 1'b1;
      end
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Throttle follows occupancy; error is sticky until any reset.
  always_ff @(posedge clk_i) begin
    if (rst_i || frst_rise) begin
      throttle_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      throttle_o <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) >= (AW+1)'(AFULL);
      if (trig_rise && full) error_o <= 1'b1;
    end
  end

  logic [$clog2(SYSRST_CYC+1)-1:0] srst_cnt_r;
  // Fast reset becomes a held system reset toward the personality.
  always_ff @(posedge clk_i) begin
    if (rst_i || frst_rise) srst_cnt_r <= ($clog2(SYSRST_CYC+1))'(SYSRST_CYC);
    else if (srst_cnt_r != '0) srst_cnt_r <= srst_cnt_r - 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) pif.sys_rst <= 1'b1;
    else pif.sys_rst <= srst_cnt_r != '0;
  end

  logic [DATA_W-1:0] tx_r, rx_r;
  logic tx_pend_r, rx_val_r, perr_r;
  logic [15:0] evt_r;
  logic dir;
  assign dir = ctrl_r[CTRL_DIR];
  // Link side: each settled serial clock rise moves one word.
  always_ff @(posedge clk_i) begin
    if (rst_i || frst_rise) begin
      tx_r <= '0;
      tx_pend_r <= 1'b0;
      rx_r <= '0;
      rx_val_r <= 1'b0;
      evt_r <= 16'h0000;
    end else begin
      if (wr && wb_adr_i == REG_TX) begin
        tx_r <= wb_dat_i[DATA_W-1:0];
        tx_pend_r <= 1'b1;
      end else if (sclk_rise && dir) begin
        tx_pend_r <= 1'b0;
      end
      if (rd && wb_adr_i == REG_RX) rx_val_r <= 1'b0;
      if (sclk_rise && !dir) begin
        rx_r <= s_data;
        rx_val_r <= 1'b1;
        evt_r <= evt_r + 16'h0001;
      end
    end
  end
  // Personality error is held for software.
  always_ff @(posedge clk_i) begin
    if (rst_i) perr_r <= 1'b0;
    else if (s_perr) perr_r <= 1'b1;
  end
  // Link outputs; the card drives data only in the outbound direction.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pif.dir <= 1'b0;
      pif.rc_oe <= 1'b0;
      pif.rc_data <= '0;
      pif.out_avail <= 1'b0;
    end else begin
      pif.dir <= dir;
      pif.rc_oe <= dir;
      pif.rc_data <= tx_r;
      pif.out_avail <= dir & tx_pend_r & ~(sclk_rise & ~(wr && wb_adr_i == REG_TX));
    end
  end

  // Read data and ack; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= ctrl_r;
          REG_FIRE: wb_dat_o <= {31'h0000_0000, fire_pend_r};
          REG_DELAY: wb_dat_o <= {16'h0000, delay_r};
          REG_FIFO: wb_dat_o <= {15'h0000, !empty, mem_r[rp_r]};
          REG_STATUS: wb_dat_o <= {18'h00000, rx_val_r, tx_pend_r, perr_r, error_o,
                                   throttle_o, full, 3'h0, 5'(cnt_r)};
          REG_RX: wb_dat_o <= {evt_r, rx_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : rtbf_readout_card
`default_nettype wire

/* File: design/rtbf_personality.sv */
/*
  Detector personality end of the link: makes the gated serial clock,
  sends words into the card or takes words from it per direction.
  Assumes link levels from the card are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module rtbf_personality
  import rtbf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [rtbf_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [rtbf_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic xmit_err_i,
  output logic [15:0] evt_cnt_o,
  rtbf_pif.pers pif
);
  typedef enum logic [1:0] {RTBF_IDLE = 2'b00, RTBF_SETUP = 2'b01, RTBF_HIGH = 2'b11,
                            RTBF_GAP = 2'b10} rtbf_st_t;
  localparam int CW = 4;
  localparam logic [CW-1:0] HALF = CW'(SCLK_HALF_CYC);

  initial begin
    if (SCLK_HALF_CYC < 1 || 2 * SCLK_HALF_CYC >= (1 << CW)) $error("rtbf_personality: bad clock");
  end

  logic s_dir, s_avail, s_rst;
  logic [DATA_W-1:0] s_data;
  rtbf_sync3 #(.W(DATA_W + 3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({pif.dir, pif.out_avail, pif.sys_rst, pif.data}),
    .q_o({s_dir, s_avail, s_rst, s_data})
  );

  rtbf_st_t st_r;
  logic [CW-1:0] cnt_r;
  logic out_r;
  // Serial clock runs only while a word moves, then idles low.
  always_ff @(posedge clk_i) begin
    if (rst_i || s_rst) begin
      st_r <= RTBF_IDLE;
      cnt_r <= '0;
      out_r <= 1'b0;
      pif.sclk <= 1'b0;
    end else begin
      unique case (st_r)
        RTBF_IDLE: begin
          cnt_r <= '0;
          if (!s_dir && tx_valid_i) begin
            out_r <= 1'b0;
            st_r <= RTBF_SETUP;
          end else if (s_dir && s_avail) begin
            out_r <= 1'b1;
            st_r <= RTBF_SETUP;
          end
        end
        RTBF_SETUP: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == HALF - 1'b1) begin
            cnt_r <= '0;
            pif.sclk <= 1'b1;
            st_r <= RTBF_HIGH;
          end
        end
        RTBF_HIGH: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == HALF - 1'b1) begin
            cnt_r <= '0;
            pif.sclk <= 1'b0;
            st_r <= RTBF_GAP;
          end
        end
        RTBF_GAP: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == 2 * HALF - 1'b1) st_r <= RTBF_IDLE;
        end
      endcase
    end
  end

  // Inbound words are driven from setup until the gap ends.
  always_ff @(posedge clk_i) begin
    if (rst_i || s_rst) begin
      pif.pl_oe <= 1'b0;
      pif.pl_data <= '0;
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= st_r == RTBF_IDLE && !s_dir && tx_valid_i;
      if (st_r == RTBF_IDLE && !s_dir && tx_valid_i) begin
        pif.pl_data <= tx_data_i;
        pif.pl_oe <= 1'b1;
      end else if (st_r == RTBF_IDLE) begin
        pif.pl_oe <= 1'b0;
      end
    end
  end

  // Outbound words are taken at the clock rise; one counter per strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i || s_rst) begin
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      evt_cnt_o <= 16'h0000;
    end else begin
      rx_valid_o <= st_r == RTBF_SETUP && cnt_r == HALF - 1'b1 && out_r;
      if (st_r == RTBF_SETUP && cnt_r == HALF - 1'b1) begin
        evt_cnt_o <= evt_cnt_o + 16'h0001;
        if (out_r) rx_data_o <= s_data;
      end
    end
  end

  // Transmission error report toward the card.
  always_ff @(posedge clk_i) begin
    if (rst_i) pif.perr <= 1'b0;
    else pif.perr <= xmit_err_i;
  end
endmodule : rtbf_personality
`default_nettype wire

/* File: verif/rtbf_link_monitor.sv */
/*
  Checker for the personality link between the card and personality ends.
  Assumes it sees the link signals with the card's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rtbf_link_monitor
  import rtbf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic dir,
  input wire logic sys_rst,
  input wire logic rc_oe,
  input wire logic pl_oe,
  input wire logic [rtbf_pkg::DATA_W-1:0] pl_data
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A strobe is four cycles high, then an eight-cycle low gap.
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_gap;
    !sclk [*8];
  endsequence
  a_sclk_high_time: assert property ($rose(sclk) |-> s_high)
    else $error("serial clock high time wrong");
  a_sclk_low_gap: assert property ($fell(sclk) |-> s_gap)
    else $error("serial clock gap too short");
  a_bus_one_driver: assert property (!(rc_oe && pl_oe))
    else $error("both ends drive the data bus");
  a_card_drive_dir: assert property (rc_oe |-> dir)
    else $error("card drives bus against direction");
  a_pers_drive_dir: assert property (pl_oe |-> !dir)
    else $error("personality drives bus against direction");
  a_sclk_has_word: assert property ($rose(sclk) |-> (rc_oe || pl_oe))
    else $error("serial clock runs with no word on the bus");
  a_word_setup: assert property ($rose(sclk) && !dir |-> $past(pl_oe, 4) && $stable(pl_data))
    else $error("inbound word not set up before the strobe");
  a_sysrst_hold: assert property ($fell(rst_i) |-> sys_rst [*7])
    else $error("system reset to the link too short");
  a_idle_in_reset: assert property (sys_rst [*7] |-> !sclk && !pl_oe)
    else $error("personality not idle under system reset");
  a_bus_release: assert property ($fell(sclk) && !dir |-> ##[1:12] !pl_oe)
    else $error("personality keeps the bus after a word");
  c_outbound: cover property ($rose(sclk) && dir);
endmodule : rtbf_link_monitor
`default_nettype wire

/* File: verif/rtbf_bench.sv */
/*
  Bench joining the readout card and personality ends over the link.
  Assumes the design package, interface and modules are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rtbf_bench;
  import rtbf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, crst = 1'b0;
  logic [7:0] adr = 8'h00, ctrig = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, ts;
  logic ftrig, fcal, frst, cthr, cerr, thr, err, txv = 1'b0, xerr = 1'b0, txr, rxv;
  logic [15:0] cthr_in = 16'h0, cerr_in = 16'h0, txd = 16'h0, rxd, evt;
  int n_mismatch = 0, num_checks = 0, k, w, c;
  rtbf_pif rtbf_pif_inst();
  // The card's own bus outputs loop back as its view of the crate bus.
  rtbf_readout_card rtbf_readout_card_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cen_trig_i(ctrig), .cen_cal_i(8'h00), .cen_rst_i(crst),
    .fcb_trig_o(ftrig), .fcb_cal_o(fcal), .fcb_rst_o(frst), .fcb_trig_i(ftrig),
    .fcb_rst_i(frst), .card_throttle_i(cthr_in), .card_err_i(cerr_in),
    .cen_throttle_o(cthr), .cen_err_o(cerr), .throttle_o(thr), .error_o(err),
    .pif(rtbf_pif_inst));
  rtbf_personality rtbf_personality_inst (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv),
    .xmit_err_i(xerr), .evt_cnt_o(evt), .pif(rtbf_pif_inst));
  rtbf_link_monitor rtbf_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(rtbf_pif_inst.sclk), .dir(rtbf_pif_inst.dir), .sys_rst(rtbf_pif_inst.sys_rst),
    .rc_oe(rtbf_pif_inst.rc_oe), .pl_oe(rtbf_pif_inst.pl_oe), .pl_data(rtbf_pif_inst.pl_data));
  // Free-running 25 MHz clock.
  always #(CLK_NS / 2) clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, w_en, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, exp, q & m);
  endtask : rdchk
  // Central strobe pulse; bit 8 is the fast reset, bits 7:0 the partitions.
  task automatic pulse(input logic [8:0] m);
    {crst, ctrig} <= m;
    repeat (6) @(posedge clk_i);
    {crst, ctrig} <= 9'h000;
    repeat (16) @(posedge clk_i);
  endtask : pulse
  // Personality sends one word into the card.
  task automatic send(input logic [15:0] d);
    {txd, txv} <= {d, 1'b1};
    @(posedge clk_i);
    while (txr !== 1'b1) @(posedge clk_i);
    txv <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask : send
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("ctrl_reset", REG_CTRL, 32'hFFFFFFFF, CTRL_RST);
    rdchk("status_reset", REG_STATUS, 32'h3FFF, 32'h0);
    rdchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, REG_CTRL, 32'h3 << CTRL_PART);
    pulse(9'h020);
    rdchk("other_part", REG_STATUS, 32'h1F, 32'h0);
    for (k = 0; k <= FIFO_DEPTH; k++) begin
      pulse(9'h008);
      c = (k < FIFO_DEPTH) ? k + 1 : FIFO_DEPTH;
      ts = c | (32'(c == FIFO_DEPTH) << ST_FULL) | (32'(c >= FIFO_AFULL) << ST_THR);
      rdchk("fifo_status", REG_STATUS, 32'h71F, ts | (32'(k >= FIFO_DEPTH) << ST_ERR));
      chk("throttle", 32'(c >= FIFO_AFULL), {31'h0, thr});
      chk("error", 32'(k >= FIFO_DEPTH), {31'h0, err});
    end
    wb(1'b0, REG_FIFO, 32'h0);
    ts = q;
    wb(1'b0, REG_FIFO, 32'h0);
    chk("pop_valid", 32'h1, 32'(q[FIFO_VALID] & ts[FIFO_VALID]));
    chk("ts_order", 32'h1, 32'(q[15:0] > ts[15:0]));
    repeat (3) wb(1'b0, REG_FIFO, 32'h0);
    rdchk("after_pop", REG_STATUS, 32'h71F, 32'h40B);
    chk("throttle_drop", 32'h0, {31'h0, thr});
    pulse(9'h100);
    rdchk("fast_reset", REG_STATUS, 32'h71F, 32'h0);
    wb(1'b1, REG_CTRL, 32'h1 << CTRL_GEN);
    wb(1'b1, REG_DELAY, 32'h28);
    wb(1'b1, REG_FIRE, 32'h1 << FIRE_TRIG);
    rdchk("fire_pending", REG_FIRE, 32'h1, 32'h1);
    repeat (60) @(posedge clk_i);
    wb(1'b1, REG_DELAY, 32'h6);
    for (int b = 0; b < 2; b++) begin
      wb(1'b1, REG_FIRE, 32'h1 << b);
      for (k = 0; k < 60 && (b ? fcal : ftrig) !== 1'b1; k++) @(posedge clk_i);
      for (w = 0; w < 20 && (b ? fcal : ftrig) === 1'b1; w++) @(posedge clk_i);
      chk("strobe_delay", 32'h1, 32'(k >= 4));
      chk("strobe_width", STROBE_CYC, w);
    end
    pulse(9'h008);
    rdchk("gen_fifo", REG_STATUS, 32'h1F, 32'h2);
    send(16'hA5C3);
    rdchk("rx_valid", REG_STATUS, 32'h1 << ST_RXV, 32'h1 << ST_RXV);
    rdchk("rx_word", REG_RX, 32'hFFFFFFFF, 32'h0001A5C3);
    rdchk("rx_clear", REG_STATUS, 32'h1 << ST_RXV, 32'h0);
    send(16'h5A3C);
    rdchk("rx_word2", REG_RX, 32'hFFFFFFFF, 32'h00025A3C);
    wb(1'b1, REG_CTRL, 32'h1 << CTRL_DIR);
    wb(1'b1, REG_TX, 32'h3C5A);
    for (k = 0; k < 80 && rxv !== 1'b1; k++) @(posedge clk_i);
    chk("pers_rx", 32'h3C5A, {16'h0, rxd});
    repeat (20) @(posedge clk_i);
    chk("evt_cnt", 32'h3, {16'h0, evt});
    xerr <= 1'b1;
    repeat (8) @(posedge clk_i);
    xerr <= 1'b0;
    rdchk("perr", REG_STATUS, 32'h1 << ST_PERR, 32'h1 << ST_PERR);
    pulse(9'h100);
    chk("evt_reset", 32'h0, {16'h0, evt});
    rdchk("rx_cnt_reset", REG_RX, 32'hFFFF0000, 32'h0);
    {cthr_in, cerr_in} <= {16'h8000, 16'h0001};
    repeat (10) @(posedge clk_i);
    chk("cen_lines", 32'h3, {30'h0, cthr, cerr});
    {cthr_in, cerr_in} <= 32'h0;
    repeat (10) @(posedge clk_i);
    chk("cen_clear", 32'h0, {30'h0, cthr, cerr});
    test_done();
  end
endmodule : rtbf_bench
`default_nettype wire
